// >>> sim/acf_adc_regs_assertions.sv
// Port checks for the converter register block
`timescale 1ns/1ns
`default_nettype none
module acf_adc_regs_assertions (
  input wire clk,
  input wire reset,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_awready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire convClk,
  input wire convClkIsRc
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_reset_idle: assert property ($fell(reset) |-> !convClkIsRc && !convClk)
    else $error("clock outputs not idle after reset");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |-> ##2
    s_axi_rvalid) else $error("read answer late");
  a_rdata_upper: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h00_0000) else $error("upper bits set");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid) else $error("write answer dropped");
  a_resp_after_w: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:8]
    s_axi_bvalid) else $error("write answer missing");
  a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready &&
    !s_axi_wready) else $error("new write taken while busy");
  // RC clock toggles every 25 cycles, so it never moves twice in 9;
  // leaving RC mode hands the pin to the divider, which may move at once
  a_rc_slow: assert property (convClkIsRc && $past(convClkIsRc) &&
    $changed(convClk) |=> (!convClkIsRc || $stable(convClk)) [*8])
    else $error("rc fast");
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_rc: cover property (convClkIsRc && $changed(convClk));
endmodule // acf_adc_regs_assertions
`default_nettype wire

// >>> sim/acf_conv_model.sv
// Behavioural conversion core answering with a one-cycle done pulse
`timescale 1ns/1ns
`default_nettype none
module acf_conv_model (
  input wire clk,
  input wire convClk,
  input wire start,
  input wire [9:0] value,
  input wire [3:0] edges,
  output logic convDone,
  output logic [9:0] convResult
);
  logic busy = 0;
  logic last = 0;
  int cnt = 0;
  initial begin
    convDone = 0;
    convResult = 0;
  end
  always @(posedge clk) begin
    last <= convClk;
    convDone <= 0;
    // Result is only valid with the pulse, so it churns otherwise
    convResult <= ~convResult;
    if (start) begin
      busy <= 1;
      cnt <= 0;
    end else if (busy && convClk && !last) begin
      if (cnt == edges) begin
        busy <= 0;
        convDone <= 1;
        convResult <= value;
      end
      cnt <= cnt + 1;
    end
  end
endmodule // acf_conv_model
`default_nettype wire

// >>> sim/tb.sv
// Self-checking bench for the converter register block
`timescale 1ns/1ns
`default_nettype none
`include "acf_defines.vh"
module tb;
  logic clk = 0, reset = 1, start = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, convDone, convClk, convClkIsRc;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, got;
  logic [3:0] s_axi_wstrb = 4'hF, edges = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [9:0] convResult, value = 0, v;
  int n_fail = 0, total_checks = 0;
  int hp[8] = '{1, 4, 16, 25, 2, 8, 32, 25};
  acf_adc_regs dut (.*);
  acf_conv_model core (.*);
  initial forever #20 clk = ~clk;
  task chk(input [31:0] g, input [31:0] e, input [31:0] m);
    total_checks++;
    if ((g & m) !== (e & m)) begin
      n_fail++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
    s_axi_bready <= 1;
    do @(posedge clk); while (!s_axi_bvalid);
    resp = s_axi_bresp; s_axi_bready <= 0;
  endtask
  task rd(input [11:0] a);
    s_axi_araddr <= a; s_axi_arvalid <= 1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 0; s_axi_rready <= 1;
    do @(posedge clk); while (!s_axi_rvalid);
    got = s_axi_rdata; resp = s_axi_rresp; s_axi_rready <= 0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_clksel;
    int n;
    logic l;
    for (int c = 0; c < 8; c++) begin
      // Unimplemented bits are written as ones to see them dropped
      wr(`ACF_OFF_CLKCTL, c * 16 + 32'h0000_008F);
      chk(resp, `ACF_RESP_OKAY, 3);
      rd(`ACF_OFF_CLKCTL); chk(got, c * 16, 32'hFFFF_FFFF);
      repeat (60) @(posedge clk);
      chk(convClkIsRc, c % 4 == 3, 1);
      n = 0; l = convClk;
      while (convClk === l) @(posedge clk);
      l = convClk;
      while (convClk === l && n < 100) begin @(posedge clk); n++; end
      chk(n, hp[c], 32'hFFFF_FFFF);
    end
  endtask
  task t_format;
    for (int f = 0; f < 2; f++) begin
      wr(`ACF_OFF_FORMAT, f);
      v = f ? 10'h2B5 : 10'h36A;
      value <= v; edges <= f ? 9 : 0; start <= 1;
      @(posedge clk); start <= 0;
      do @(posedge clk); while (!convDone);
      rd(`ACF_OFF_STATUS); chk(got, 3, 32'hFFFF_FFFF);
      // Flipping the format later must leave the stored layout alone
      wr(`ACF_OFF_FORMAT, !f);
      rd(`ACF_OFF_RESHI); chk(got, f ? v[9:8] : v[9:2], f ? 3 : 255);
      rd(`ACF_OFF_RESLO); chk(got, f ? v[7:0] : {v[1:0], 6'h00}, f ? 255 : 192);
    end
  endtask
  task t_unmapped;
    rd(12'h100); chk(resp, `ACF_RESP_SLVERR, 3); chk(got, 0, 32'hFFFF_FFFF);
    wr(12'h100, 1); chk(resp, `ACF_RESP_SLVERR, 3);
    // Software write lands in the low result only; high keeps conversion
    wr(`ACF_OFF_RESLO, 32'h0000_00A5); chk(resp, `ACF_RESP_OKAY, 3);
    rd(`ACF_OFF_RESLO); chk(got, 32'h0000_00A5, 32'h0000_00FF);
    rd(`ACF_OFF_RESHI); chk(got, 2, 3);
    // Lane 0 disabled: the format bit must stay cleared
    s_axi_wstrb <= 4'hE;
    wr(`ACF_OFF_FORMAT, 1);
    s_axi_wstrb <= 4'hF;
    rd(`ACF_OFF_FORMAT); chk(got, 0, 32'hFFFF_FFFF);
  endtask
  task end_sim;
    if (n_fail == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    rd(`ACF_OFF_CLKCTL); chk(got, 0, 32'hFFFF_FFFF);
    rd(`ACF_OFF_STATUS); chk(got, 0, 32'hFFFF_FFFF);
    t_clksel;
    t_format;
    t_unmapped;
    end_sim;
  end
  initial begin
    #400000;
    n_fail++;
    end_sim;
  end
endmodule // tb
bind acf_adc_regs acf_adc_regs_assertions chk_i (.*);
`default_nettype wire

// >>> src/acf_adc_regs.v
// Converter clock select and result format register block
// Operation
// [RULE1] Select field codes 000,001,010,100,101,110 give osc/2,/8,/32,/4,/16,/64
// [RULE2] Select codes with both low bits set clock from internal RC, max 500 kHz
// [RULE3] Clock control bits 7 and 3..0 read zero; select lives in 6..4
// [RULE4] Left justified: high register holds result bits 9..2
// [RULE5] Left justified: low register bits 7..6 hold result bits 1..0
// [RULE6] Right justified: high register bits 1..0 hold result bits 9..8
// [RULE7] Right justified: low register holds result bits 7..0
// [RULE8] Both result registers load together at conversion end, current format
//
// Design decisions made here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "acf_defines.vh"
module acf_adc_regs (
  input wire clk,
  input wire reset,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire convDone,
  input wire [9:0] convResult,
  output reg convClk,
  output reg convClkIsRc
);
  ////////////////////////////////////////////////////////////////////////////
  reg [2:0] clkSel_q;
  reg format_q;
  reg loaded_q;
  reg [11:0] awAddr_q;
  reg [31:0] wData_q;
  reg [3:0] wStrb_q;
  reg awHave_q;
  reg wHave_q;
  reg [11:0] arAddr_q;
  reg rdPend_q;
  reg [5:0] divCnt_q;
  reg [5:0] rcCnt_q;
  reg rcClk_q;
  wire [7:0] storeRd;
  wire [7:0] resHigh;
  wire [7:0] resLow;
  wire doWrite;
  wire [11:0] wa;
  wire [11:0] ra;
  wire [7:0] clkCtlRd;
  wire storeWr;
  reg [5:0] halfDiv;
  localparam [31:0] RC_HALF = `ACF_RC_DIV / 2 - 1;
  wire [5:0] rcHalf;
  wire [7:0] clkCtlReset;

  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `ACF_OFF_CLKCTL) || (a == `ACF_OFF_RESHI) ||
        (a == `ACF_OFF_RESLO) || (a == `ACF_OFF_FORMAT) ||
        (a == `ACF_OFF_STATUS);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Justification
  assign resHigh = format_q ? {6'h00, convResult[9:8]} // [RULE6]
                            : convResult[9:2]; // [RULE4]
  assign resLow = format_q ? convResult[7:0] // [RULE7]
                           : {convResult[1:0], 6'h00}; // [RULE5]
  assign clkCtlRd = {1'b0, clkSel_q, 4'h0}; // [RULE3]
  assign rcHalf = RC_HALF[5:0];
  assign clkCtlReset = `ACF_CLKCTL_RESET;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path: address and data taken in either order
  assign wa = awHave_q ? awAddr_q : s_axi_awaddr;
  assign doWrite = awHave_q && wHave_q && !s_axi_bvalid;
  assign storeWr = doWrite && wStrb_q[0] &&
    ((awAddr_q == `ACF_OFF_RESHI) || (awAddr_q == `ACF_OFF_RESLO));
  assign ra = arAddr_q;

  always @(posedge clk) begin
    if (reset) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ACF_RESP_OKAY;
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awAddr_q <= 12'h000;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      clkSel_q <= clkCtlReset[`ACF_SEL_MSB:`ACF_SEL_LSB];
      format_q <= 1'b0;
    end else begin
      // Held low while a response waits, so a slow bready blocks new writes
      s_axi_awready <= !awHave_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !wHave_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_q <= 1'b1;
        awAddr_q <= {wa[11:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHave_q <= 1'b0;
        wHave_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(awAddr_q) ? `ACF_RESP_OKAY : `ACF_RESP_SLVERR;
        if (wStrb_q[0] && awAddr_q == `ACF_OFF_CLKCTL)
          clkSel_q <= wData_q[`ACF_SEL_MSB:`ACF_SEL_LSB]; // [RULE3]
        if (wStrb_q[0] && awAddr_q == `ACF_OFF_FORMAT)
          format_q <= wData_q[0];
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result store: conversion load beats a software write in the same cycle
  acf_result_store uStore (
    .clk(clk),
    .wrEn(storeWr),
    .wrSel(awAddr_q == `ACF_OFF_RESHI),
    .wrData(wData_q[7:0]),
    .loadEn(convDone), // [RULE8]
    .loadHigh(resHigh),
    .loadLow(resLow),
    .rdSel(s_axi_araddr[11:2] == `ACF_OFF_RESHI >> 2),
    .rdData(storeRd)
  );

  always @(posedge clk) begin
    if (reset)
      loaded_q <= 1'b0;
    else if (convDone)
      loaded_q <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path: address taken, store read registered, data next
  always @(posedge clk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `ACF_RESP_OKAY;
      arAddr_q <= 12'h000;
      rdPend_q <= 1'b0;
    end else begin
      s_axi_arready <= !rdPend_q && !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        arAddr_q <= {s_axi_araddr[11:2], 2'b00};
        rdPend_q <= 1'b1;
      end
      if (rdPend_q) begin
        rdPend_q <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= mapped(ra) ? `ACF_RESP_OKAY : `ACF_RESP_SLVERR;
        case (ra)
          `ACF_OFF_CLKCTL: s_axi_rdata <= {24'h00_0000, clkCtlRd};
          `ACF_OFF_RESHI: s_axi_rdata <= {24'h00_0000, storeRd};
          `ACF_OFF_RESLO: s_axi_rdata <= {24'h00_0000, storeRd};
          `ACF_OFF_FORMAT: s_axi_rdata <= {31'h0000_0000, format_q};
          `ACF_OFF_STATUS: s_axi_rdata <= {30'h0000_0000, loaded_q,
                                           convClkIsRc};
          default: s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion clock; divide-by-2 at 25 MHz needs a toggle every edge
  always @* begin
    case (clkSel_q)
      3'b000: halfDiv = 6'd1; // [RULE1]
      3'b001: halfDiv = 6'd4; // [RULE1]
      3'b010: halfDiv = 6'd16; // [RULE1]
      3'b100: halfDiv = 6'd2; // [RULE1]
      3'b101: halfDiv = 6'd8; // [RULE1]
      3'b110: halfDiv = 6'd32; // [RULE1]
      default: halfDiv = 6'd1;
    endcase
  end

  // RC stand-in: divided so it never exceeds the 500 kHz ceiling
  always @(posedge clk) begin
    if (reset) begin
      rcCnt_q <= 6'd0;
      rcClk_q <= 1'b0;
    end else if (rcCnt_q == rcHalf) begin
      rcCnt_q <= 6'd0;
      rcClk_q <= !rcClk_q;
    end else begin
      rcCnt_q <= rcCnt_q + 6'd1;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      divCnt_q <= 6'd0;
      convClk <= 1'b0;
      convClkIsRc <= 1'b0;
    end else begin
      convClkIsRc <= (clkSel_q[1:0] == 2'b11); // [RULE2]
      if (clkSel_q[1:0] == 2'b11) begin
        divCnt_q <= 6'd0;
        convClk <= rcClk_q; // [RULE2]
      end else if (divCnt_q >= halfDiv - 6'd1) begin
        divCnt_q <= 6'd0;
        convClk <= !convClk; // [RULE1]
      end else begin
        divCnt_q <= divCnt_q + 6'd1;
      end
    end
  end
endmodule // acf_adc_regs
`default_nettype wire

// >>> src/acf_defines.vh
// Register map, field positions and timing constants of the converter block
`ifndef ACF_DEFINES_VH
`define ACF_DEFINES_VH
`define ACF_OFF_CLKCTL 12'h000
`define ACF_OFF_RESHI 12'h004
`define ACF_OFF_RESLO 12'h008
`define ACF_OFF_FORMAT 12'h00C
`define ACF_OFF_STATUS 12'h010
`define ACF_CLKCTL_RESET 8'h00
`define ACF_SEL_LSB 4
`define ACF_SEL_MSB 6
`define ACF_CLKCTL_MASK 8'h70
`define ACF_OSC_HZ 25000000
`define ACF_RC_MAX_HZ 500000
`define ACF_RC_DIV ((`ACF_OSC_HZ + `ACF_RC_MAX_HZ - 1) / `ACF_RC_MAX_HZ)
`define ACF_RESP_OKAY 2'b00
`define ACF_RESP_SLVERR 2'b10
`endif

// >>> src/acf_result_store.v
// Result register pair, loaded together and read out through a register
`timescale 1ns/1ns
`default_nettype none
module acf_result_store (
  input wire clk,
  input wire wrEn,
  input wire wrSel,
  input wire [7:0] wrData,
  input wire loadEn,
  input wire [7:0] loadHigh,
  input wire [7:0] loadLow,
  input wire rdSel,
  output reg [7:0] rdData
);
  reg [7:0] mem [0:1];
  // No reset: contents stay undefined until loaded by a conversion or a software write
  always @(posedge clk) begin
    if (loadEn) begin
      mem[1] <= loadHigh;
      mem[0] <= loadLow;
    end else if (wrEn) begin
      mem[wrSel] <= wrData;
    end
    rdData <= mem[rdSel];
  end
endmodule // acf_result_store
`default_nettype wire
